// File: src/amp_ctl_pkg.sv
// Purpose: Shared constants and types for the amplifier control port and its host
// Assumes: 250 MHz system clock on both ends
// Notes:   Host register map is a Wishbone word map
package amp_ctl_pkg;

  localparam int CLK_PERIOD_NS = 4;

  // Frame-enable high time that commits or aborts a shift frame
  localparam int FRAME_HIGH_NS = 100;
  localparam int FRAME_HIGH_CYC = (FRAME_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] FRAME_HIGH_LAST = 5'(FRAME_HIGH_CYC - 1);

  // Host link timing, one bit is four quarter periods
  localparam int I2C_PERIOD_NS = 2500;
  localparam int SPI_PERIOD_NS = 1000;
  localparam int I2C_QUARTER_CYC = (I2C_PERIOD_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SPI_QUARTER_CYC = (SPI_PERIOD_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] I2C_QUARTER_LAST = 8'(I2C_QUARTER_CYC - 1);
  localparam logic [7:0] SPI_QUARTER_LAST = 8'(SPI_QUARTER_CYC - 1);

  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_SHIFT_BIT = 4'h7;

  // Address and byte tags
  localparam logic [5:0] ADDR_PREFIX = 6'h3E;
  localparam logic [3:0] TAG_MODE = 4'h0;
  localparam logic [3:0] TAG_SPATIAL = 4'h4;
  localparam logic [2:0] TAG_MONO = 3'h4;
  localparam logic [2:0] TAG_LEFT = 3'h6;
  localparam logic [2:0] TAG_RIGHT = 3'h7;

  // Field positions in a data byte
  localparam int CAPLESS_BIT = 3;
  localparam int SPATIAL_ON_BIT = 0;
  localparam int SPATIAL_WIDTH_BIT = 1;
  localparam int SPATIAL_LO_BIT = 2;
  localparam int SPATIAL_HI_BIT = 3;

  // Values after reset
  localparam logic [2:0] MODE_RESET = 3'h0;
  localparam logic CAPLESS_RESET = 1'h0;
  localparam logic [3:0] SPATIAL_RESET = 4'h0;
  localparam logic [4:0] GAIN_RESET = 5'h00;
  localparam logic [3:0] PIN_IDLE = 4'h7;

  // Host registers
  localparam logic [7:0] CMD_OFS = 8'h00;
  localparam logic [7:0] CFG_OFS = 8'h04;
  localparam logic [7:0] STAT_OFS = 8'h08;
  localparam int CMD_LAST_BIT = 8;
  localparam int CFG_SPI_BIT = 0;
  localparam int CFG_ASEL_BIT = 1;
  localparam logic [1:0] CFG_RESET = 2'h0;

  typedef enum logic [2:0] {
    TGT_NONE    = 3'h0,
    TGT_MODE    = 3'h1,
    TGT_SPATIAL = 3'h2,
    TGT_MONO    = 3'h3,
    TGT_LEFT    = 3'h4,
    TGT_RIGHT   = 3'h5
  } target_e;

  typedef enum logic [2:0] {
    I_IDLE     = 3'h0,
    I_ADDR     = 3'h1,
    I_ADDR_ACK = 3'h2,
    I_DATA     = 3'h3,
    I_DATA_ACK = 3'h4,
    I_SKIP     = 3'h5
  } dev_state_e;

  typedef enum logic [2:0] {
    H_IDLE      = 3'h0,
    H_START     = 3'h1,
    H_BIT       = 3'h2,
    H_HOLD      = 3'h3,
    H_STOP      = 3'h4,
    H_FRAME_ON  = 3'h5,
    H_FRAME_OFF = 3'h6
  } host_state_e;

endpackage : amp_ctl_pkg

// File: src/amp_ctl_if.sv
// Purpose: Pins between host controller and amplifier control port
// Assumes: sda is open drain with pull-up in two-wire mode
// Notes:   The wire level is resolved here from both enables
`default_nettype none
interface amp_ctl_if;
  logic scl;
  logic frame_enable;
  logic interface_select;
  logic sda_host_o;
  logic sda_host_oe;
  logic sda_dev_o;
  logic sda_dev_oe;
  logic sda;

  // Low wins, pull-up otherwise
  assign sda = ~((sda_host_oe & ~sda_host_o) | (sda_dev_oe & ~sda_dev_o));

  modport device(
    input  scl,
    input  sda,
    input  frame_enable,
    input  interface_select,
    output sda_dev_o,
    output sda_dev_oe
  );

  modport host(
    output scl,
    output frame_enable,
    output interface_select,
    output sda_host_o,
    output sda_host_oe,
    input  sda
  );
endinterface : amp_ctl_if
`default_nettype wire

// File: src/amp_ctl_device.sv
// Purpose: Write-only control port of an audio amplifier, two-wire or shift mode
// Assumes: Link pins are asynchronous to clk_i and filtered here
// Notes:   Control registers cannot be read back
// Function
// - Strap low two-wire, high shift interface
// - Answer address 111110, select pin, zero
// - Start is sda fall with scl high
// - Address bits MSB first on scl rise
// - Hold sda low through matched ack
// - Host abandons transfer on missing ack
// - Data byte MSB first, device acknowledges
// - Several data bytes per transfer decoded
// - Stop is sda rise with scl high
// - Two-wire clock at most standard rate; host and checker use a 2500 ns period, 400 kHz
// - Shift data MSB first on rise
// - Shift clock at most 1 MHz
// - Frame enable low only while shifting
// - Short frame then high discards word
// - Keep first eight bits, apply on rise; code applies once enable has stayed high 100 ns
// - Host holds frame enable high after frame
// - No coincident clock and enable edges
// - Tags 100, 110, 111 write gains
// - Top nibble zero writes mode, capless
// - Output mode zero after power-on
// - Capless bit three, default zero
// - Tag 0100 writes spatial effect settings
//
// Register access over Wishbone and the register addresses were chosen for this implementation.
`default_nettype none
module amp_ctl_device (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  amp_ctl_if.device       link,
  output logic [2:0]      output_mode_field_o,
  output logic            capless_output_select_o,
  output logic            spatial_on_o,
  output logic            spatial_width_o,
  output logic            spatial_level_hi_o,
  output logic            spatial_level_lo_o,
  output logic [4:0]      mono_gain_field_o,
  output logic [4:0]      left_gain_field_o,
  output logic [4:0]      right_gain_field_o,
  output logic            shutdown_state_o
);
  import amp_ctl_pkg::*;

  function automatic target_e decode_target(input logic [7:0] b);
    target_e t;
    t = TGT_NONE;
    if (b[7:4] == TAG_MODE) begin
      t = TGT_MODE;
    end else if (b[7:4] == TAG_SPATIAL) begin
      t = TGT_SPATIAL;
    end else if (b[7:5] == TAG_MONO) begin
      t = TGT_MONO;
    end else if (b[7:5] == TAG_LEFT) begin
      t = TGT_LEFT;
    end else if (b[7:5] == TAG_RIGHT) begin
      t = TGT_RIGHT;
    end
    return t;
  endfunction : decode_target

  // Pin filtering: three stages, a change counts when stages two and three agree
  logic [3:0] pin_raw;
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic [3:0] sync3;
  logic [3:0] filt;
  logic [3:0] filt_q;

  assign pin_raw = {link.interface_select, link.frame_enable, link.sda, link.scl};

  for (genvar i = 0; i < 4; i++) begin : g_pin
    always_ff @(posedge clk_i) begin
      sync1[i] <= pin_raw[i];
      sync2[i] <= sync1[i];
      sync3[i] <= sync2[i];
      if (rst_i) begin
        filt[i] <= PIN_IDLE[i];
      end else if (sync2[i] == sync3[i]) begin
        filt[i] <= sync3[i];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      filt_q <= PIN_IDLE;
    end else begin
      filt_q <= filt;
    end
  end

  wire scl_f    = filt[0];
  wire sda_f    = filt[1];
  wire enb_f    = filt[2];
  wire spi_mode = filt[3];

  wire scl_rise = scl_f & ~filt_q[0];
  wire scl_fall = ~scl_f & filt_q[0];
  wire enb_rise = enb_f & ~filt_q[2];
  wire enb_fall = ~enb_f & filt_q[2];
  wire start_cond = ~spi_mode & scl_f & filt_q[0] & filt_q[1] & ~sda_f;
  wire stop_cond = ~spi_mode & scl_f & filt_q[0] & ~filt_q[1] & sda_f;

  // Two-wire receiver
  dev_state_e i_state;
  dev_state_e next_i_state;
  logic [3:0] i_bitn;
  logic [7:0] i_shreg;
  logic       ack_drive;

  wire i_recv = (i_state == I_ADDR) | (i_state == I_DATA);
  wire i_ack  = (i_state == I_ADDR_ACK) | (i_state == I_DATA_ACK);
  wire i_full = (i_bitn == BYTE_BITS);
  wire addr_match = (i_shreg[7:2] == ADDR_PREFIX) & (i_shreg[1] == enb_f) & ~i_shreg[0];

  always_comb begin
    next_i_state = i_state;
    case (i_state)
      I_IDLE: begin
        next_i_state = I_IDLE;
      end
      I_ADDR: begin
        if (scl_fall && i_full) begin
          next_i_state = addr_match ? I_ADDR_ACK : I_SKIP;
        end
      end
      I_DATA: begin
        if (scl_fall && i_full) begin
          next_i_state = I_DATA_ACK;
        end
      end
      I_ADDR_ACK, I_DATA_ACK: begin
        if (scl_fall) begin
          next_i_state = I_DATA;
        end
      end
      I_SKIP: begin
        next_i_state = I_SKIP;
      end
      default: begin
        next_i_state = I_IDLE;
      end
    endcase
    if (start_cond) begin
      next_i_state = I_ADDR;
    end else if (stop_cond || spi_mode) begin
      next_i_state = I_IDLE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      i_state <= I_IDLE;
      i_bitn  <= 4'h0;
      i_shreg <= 8'h00;
    end else begin
      i_state <= next_i_state;
      if (start_cond || (i_ack && scl_fall)) begin
        i_bitn <= 4'h0;
      end else if (i_recv && scl_rise && !i_full) begin
        i_shreg <= {i_shreg[6:0], sda_f};
        i_bitn  <= i_bitn + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_drive <= 1'b0;
    end else begin
      ack_drive <= (next_i_state == I_ADDR_ACK) | (next_i_state == I_DATA_ACK);
    end
  end

  assign link.sda_dev_oe = ack_drive;
  assign link.sda_dev_o  = 1'b0;

  wire i_apply = (i_state == I_DATA) & scl_fall & i_full;

  // Shift receiver; a short high glitch on enable does not end the frame
  logic [3:0] sp_bitn;
  logic [7:0] sp_shreg;
  logic       sp_pend;
  logic [4:0] sp_timer;

  wire sp_expire = sp_pend & enb_f & (sp_timer == FRAME_HIGH_LAST);
  // apply first eight after enable high
  wire sp_apply  = spi_mode & sp_expire & (sp_bitn == BYTE_BITS);

  always_ff @(posedge clk_i) begin
    if (rst_i || !spi_mode) begin
      sp_bitn  <= 4'h0;
      sp_shreg <= 8'h00;
      sp_pend  <= 1'b0;
      sp_timer <= 5'h00;
    end else begin
      if (enb_rise) begin
        sp_pend  <= 1'b1;
        sp_timer <= 5'h00;
      end else if (sp_expire) begin
        sp_pend <= 1'b0;
        sp_bitn <= 4'h0;
      end else if (enb_fall) begin
        sp_pend <= 1'b0;
        if (!sp_pend) begin
          sp_bitn <= 4'h0;
        end
      end else if (sp_pend) begin
        sp_timer <= sp_timer + 5'h01;
      end
      if (!enb_f && scl_rise && sp_bitn != BYTE_BITS) begin
        sp_shreg <= {sp_shreg[6:0], sda_f};
        sp_bitn  <= sp_bitn + 4'h1;
      end
    end
  end

  // Register decode, shared by both receivers
  wire        apply_stb  = i_apply | sp_apply;
  wire [7:0]  apply_byte = spi_mode ? sp_shreg : i_shreg;
  target_e    apply_tgt;
  assign apply_tgt = decode_target(apply_byte);

  logic [2:0] mode_reg;
  logic       capless_reg;
  logic [3:0] spatial_reg;
  logic [4:0] mono_reg;
  logic [4:0] left_reg;
  logic [4:0] right_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_reg    <= MODE_RESET;
      capless_reg <= CAPLESS_RESET;
      spatial_reg <= SPATIAL_RESET;
      mono_reg    <= GAIN_RESET;
      left_reg    <= GAIN_RESET;
      right_reg   <= GAIN_RESET;
    end else if (apply_stb) begin
      case (apply_tgt)
        TGT_MODE: begin
          mode_reg <= apply_byte[2:0];
          capless_reg <= apply_byte[CAPLESS_BIT];
        end
        TGT_SPATIAL: begin
          spatial_reg <= apply_byte[3:0];
        end
        TGT_MONO: begin
          mono_reg <= apply_byte[4:0];
        end
        TGT_LEFT: begin
          left_reg <= apply_byte[4:0];
        end
        TGT_RIGHT: begin
          right_reg <= apply_byte[4:0];
        end
        default: begin
          mode_reg <= mode_reg;
        end
      endcase
    end
  end

  assign output_mode_field_o     = mode_reg;
  assign capless_output_select_o = capless_reg;
  assign spatial_on_o            = spatial_reg[SPATIAL_ON_BIT];
  assign spatial_width_o         = spatial_reg[SPATIAL_WIDTH_BIT];
  assign spatial_level_lo_o      = spatial_reg[SPATIAL_LO_BIT];
  assign spatial_level_hi_o      = spatial_reg[SPATIAL_HI_BIT];
  assign mono_gain_field_o       = mono_reg;
  assign left_gain_field_o       = left_reg;
  assign right_gain_field_o      = right_reg;
  assign shutdown_state_o        = (mode_reg == MODE_RESET);

endmodule : amp_ctl_device
`default_nettype wire

// File: src/amp_ctl_host.sv
// Purpose: Host controller writing the amplifier control port from Wishbone
// Assumes: Classic Wishbone slave, one word per register
// Notes:   Sends one data byte per command; two-wire transfers stay open until a last byte or a missing ack
`default_nettype none
module amp_ctl_host (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  amp_ctl_if.host          link
);
  import amp_ctl_pkg::*;

  host_state_e h_state;
  logic [1:0]  q;
  logic [7:0]  div;
  logic [3:0]  bitn;
  logic [7:0]  shreg;
  logic [7:0]  data_pend;
  logic        in_addr;
  logic        last_flag;
  logic        nack;
  logic        scl_r;
  logic        sda_level;
  logic        enb_r;
  logic        cfg_spi;
  logic        cfg_asel;
  logic        sda_s1;
  logic        sda_s2;
  logic        sda_s3;
  logic        sda_f;

  // Data line filter, same scheme as the device side
  always_ff @(posedge clk_i) begin
    sda_s1 <= link.sda;
    sda_s2 <= sda_s1;
    sda_s3 <= sda_s2;
    if (rst_i) begin
      sda_f <= 1'b1;
    end else if (sda_s2 == sda_s3) begin
      sda_f <= sda_s3;
    end
  end

  wire req      = wb_cyc_i & wb_stb_i;
  wire wr_done  = req & wb_we_i & wb_ack_o;
  wire idle_ok  = (h_state == H_IDLE) | (h_state == H_HOLD);
  // Commands while busy are dropped, status shows busy
  wire cmd_wr   = wr_done & (wb_adr_i == CMD_OFS) & (&wb_sel_i[1:0]) & idle_ok;
  wire cfg_wr   = wr_done & (wb_adr_i == CFG_OFS) & wb_sel_i[0];
  wire busy     = ~idle_ok;
  wire ack_slot = (bitn == BYTE_BITS);
  wire tick     = (div == 8'h00);
  wire [7:0] q_last = cfg_spi ? SPI_QUARTER_LAST : I2C_QUARTER_LAST;
  wire [31:0] rd_data =
    (wb_adr_i == CFG_OFS)  ? {30'h0, cfg_asel, cfg_spi} :
    (wb_adr_i == STAT_OFS) ? {29'h0, h_state == H_HOLD, nack, busy} : 32'h0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      cfg_spi  <= CFG_RESET[CFG_SPI_BIT];
      cfg_asel <= CFG_RESET[CFG_ASEL_BIT];
      div      <= 8'h00;
    end else begin
      wb_ack_o <= req & ~wb_ack_o;
      wb_dat_o <= (req & ~wb_ack_o) ? rd_data : wb_dat_o;
      div      <= tick ? q_last : div - 8'h01;
      if (cfg_wr) begin
        cfg_spi  <= wb_dat_i[CFG_SPI_BIT];
        cfg_asel <= wb_dat_i[CFG_ASEL_BIT];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      h_state   <= H_IDLE;
      q         <= 2'h0;
      bitn      <= 4'h0;
      shreg     <= 8'h00;
      data_pend <= 8'h00;
      in_addr   <= 1'b0;
      last_flag <= 1'b0;
      nack      <= 1'b0;
      scl_r     <= 1'b1;
      sda_level <= 1'b1;
      enb_r     <= 1'b1;
    end else if (cmd_wr) begin
      last_flag <= wb_dat_i[CMD_LAST_BIT];
      nack <= 1'b0;
      q    <= 2'h0;
      bitn <= 4'h0;
      if (cfg_spi) begin
        shreg   <= wb_dat_i[7:0];
        h_state <= H_FRAME_ON;
      end else if (h_state == H_IDLE) begin
        shreg     <= {ADDR_PREFIX, cfg_asel, 1'b0};
        data_pend <= wb_dat_i[7:0];
        in_addr   <= 1'b1;
        h_state   <= H_START;
      end else begin
        shreg   <= wb_dat_i[7:0];
        in_addr <= 1'b0;
        h_state <= H_BIT;
      end
    end else if (tick && busy) begin
      q <= q + 2'h1;
      case (h_state)
        H_START: begin
          if (q == 2'h0) sda_level <= 1'b0;
          if (q == 2'h2) scl_r <= 1'b0;
          if (q == 2'h3) h_state <= H_BIT;
        end
        H_BIT: begin
          if (q == 2'h0) sda_level <= ack_slot ? 1'b1 : shreg[7];
          if (q == 2'h1) scl_r <= 1'b1;
          if (q == 2'h2 && ack_slot) nack <= sda_f;
          if (q == 2'h3) begin
            scl_r <= 1'b0;
            if (!ack_slot) begin
              shreg <= {shreg[6:0], 1'b0};
              bitn  <= bitn + 4'h1;
              if (cfg_spi && bitn == LAST_SHIFT_BIT) h_state <= H_FRAME_OFF;
            end else if (nack || (!in_addr && last_flag)) begin
              h_state <= H_STOP;
            end else if (in_addr) begin
              shreg   <= data_pend;
              in_addr <= 1'b0;
              bitn    <= 4'h0;
            end else begin
              h_state <= H_HOLD;
            end
          end
        end
        H_STOP: begin
          if (q == 2'h0) sda_level <= 1'b0;
          if (q == 2'h1) scl_r <= 1'b1;
          if (q == 2'h2) sda_level <= 1'b1;
          if (q == 2'h3) h_state <= H_IDLE;
        end
        // clock falls a quarter before enable
        H_FRAME_ON: begin
          if (q == 2'h0) scl_r <= 1'b0;
          // enable low only for the frame
          if (q == 2'h1) enb_r <= 1'b0;
          if (q == 2'h3) h_state <= H_BIT;
        end
        // enable high long before next use
        H_FRAME_OFF: begin
          if (q == 2'h1) enb_r <= 1'b1;
          if (q == 2'h2) scl_r <= 1'b1;
          if (q == 2'h3) h_state <= H_IDLE;
        end
        default: begin
          h_state <= H_IDLE;
        end
      endcase
    end
  end

  assign link.interface_select = cfg_spi;
  assign link.frame_enable     = cfg_spi ? enb_r : cfg_asel;
  assign link.scl              = scl_r;
  assign link.sda_host_o       = cfg_spi ? sda_level : 1'b0;
  assign link.sda_host_oe      = cfg_spi ? 1'b1 : ~sda_level;

endmodule : amp_ctl_host
`default_nettype wire

// File: dv/amp_ctl_checker.sv
// Purpose: Wire checks on the host to device control link
// Assumes: One clock domain, synchronous reset
// Notes:   Watches the first link only
`default_nettype none
module amp_ctl_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic scl,
  input wire logic sda,
  input wire logic frame_enable,
  input wire logic interface_select,
  input wire logic sda_dev_o,
  input wire logic sda_dev_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  import amp_ctl_pkg::*;

  // Shortest legal scl level, half the fastest period
  localparam int I2C_HALF_MIN = (I2C_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SPI_HALF_MIN = (SPI_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Cycles since scl last moved, saturating so long idle cannot wrap
  logic       scl_q;
  logic [9:0] scl_run;

  always_ff @(posedge clk_i) begin
    scl_q <= scl;
    if (rst_i || scl != scl_q) begin
      scl_run <= 10'h001;
    end else if (scl_run != 10'h3FF) begin
      scl_run <= scl_run + 10'h001;
    end
  end

  dev_pulls_low_a: assert property (sda_dev_oe |-> !sda_dev_o && !sda)
    else $error("device drove sda high");
  i2c_clock_rate_a: assert property (
    !interface_select && scl != scl_q |-> scl_run >= 10'(I2C_HALF_MIN))
    else $error("two-wire clock level too short");
  spi_clock_rate_a: assert property (
    interface_select && scl != scl_q |-> scl_run >= 10'(SPI_HALF_MIN))
    else $error("shift clock level too short");
  ack_starts_low_a: assert property ($rose(sda_dev_oe) |-> !scl)
    else $error("ack began with scl high");
  ack_holds_a: assert property ($rose(sda_dev_oe) |-> sda_dev_oe [*8])
    else $error("ack dropped too soon");
  ack_release_a: assert property ($fell(sda_dev_oe) |-> !scl)
    else $error("ack released with scl high");
  shift_no_ack_a: assert property (
    interface_select && $past(interface_select, 8) |-> !sda_dev_oe)
    else $error("device drove sda in shift mode");
  shift_data_stable_a: assert property (
    interface_select && !frame_enable && scl && $past(scl) |-> $stable(sda))
    else $error("shift data moved while clock high");
  no_coincide_a: assert property (
    interface_select |-> !($changed(scl) && $changed(frame_enable)))
    else $error("clock and frame enable moved together");
  frame_opens_low_a: assert property (interface_select && $fell(frame_enable) |-> !scl)
    else $error("frame opened with clock high");
endmodule : amp_ctl_checker
`default_nettype wire

// File: dv/testbench.sv
// Purpose: Host and device joined on one link, second device driven by the bench
// Assumes: Host polls busy after each command until it clears
// Notes:   Second link breaks framing on purpose
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import amp_ctl_pkg::*;

  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc, wb_stb, wb_we, wb_ack, ack2;
  logic [7:0]  wb_adr;
  logic [31:0] wb_dat, wb_rdat, rd;
  wire  [23:0] st1, st2;
  int          miscompares = 0;
  int          n_compared = 0;

  amp_ctl_if link1 ();
  amp_ctl_if link2 ();

  amp_ctl_host i_amp_ctl_host (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF),
    .wb_dat_i(wb_dat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .link(link1));
  amp_ctl_device i_amp_ctl_device (.clk_i(clk_i), .rst_i(rst_i), .link(link1),
    .output_mode_field_o(st1[23:21]), .capless_output_select_o(st1[20]),
    .spatial_level_hi_o(st1[19]), .spatial_level_lo_o(st1[18]),
    .spatial_width_o(st1[17]), .spatial_on_o(st1[16]), .mono_gain_field_o(st1[15:11]),
    .left_gain_field_o(st1[10:6]), .right_gain_field_o(st1[5:1]), .shutdown_state_o(st1[0]));
  amp_ctl_device i_amp_ctl_device_b (.clk_i(clk_i), .rst_i(rst_i), .link(link2),
    .output_mode_field_o(st2[23:21]), .capless_output_select_o(st2[20]),
    .spatial_level_hi_o(st2[19]), .spatial_level_lo_o(st2[18]),
    .spatial_width_o(st2[17]), .spatial_on_o(st2[16]), .mono_gain_field_o(st2[15:11]),
    .left_gain_field_o(st2[10:6]), .right_gain_field_o(st2[5:1]), .shutdown_state_o(st2[0]));
  amp_ctl_checker i_amp_ctl_checker (.clk_i(clk_i), .rst_i(rst_i), .scl(link1.scl),
    .sda(link1.sda), .frame_enable(link1.frame_enable),
    .interface_select(link1.interface_select), .sda_dev_o(link1.sda_dev_o),
    .sda_dev_oe(link1.sda_dev_oe));

  initial begin
    forever #2 clk_i = ~clk_i;
  end

  function automatic logic [23:0] exp_st(input logic [2:0] m, input logic c,
    input logic [3:0] s, input logic [4:0] mo, input logic [4:0] l, input logic [4:0] r);
    return {m, c, s, mo, l, r, m == 3'h0};
  endfunction : exp_st

  task automatic tally_and_finish();
    $display("compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic bail();
    miscompares++;
    $display("unexpected at %0t: wait ran out", $time);
    tally_and_finish();
  endtask : bail

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h, want %h", $time, got, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick

  // Request held until the edge that samples ack
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= we;
    wb_adr <= a;
    wb_dat <= d;
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (wb_ack !== 1'b1 && i < 20);
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (wb_ack !== 1'b1) bail();
  endtask : wb

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask : rdchk

  task automatic send(input logic [8:0] b);
    int i;
    wb(1'b1, CMD_OFS, {23'h0, b});
    for (i = 0; i < 8000; i++) begin
      wb(1'b0, STAT_OFS, 32'h0);
      if (rd[0] === 1'b0) break;
    end
    if (i == 8000) bail();
  endtask : send

  // Bench shift master, 160 ns clock; pulses past eight repeat ~b[0]
  task automatic frame2(input logic [7:0] b, input int pulses);
    int k;
    link2.scl <= 1'b0;
    tick(30);
    link2.frame_enable <= 1'b0;
    tick(20);
    for (k = 0; k < pulses; k++) begin
      link2.sda_host_o <= (k < 8) ? b[7 - k] : ~b[0];
      tick(10);
      link2.scl <= 1'b1;
      tick(20);
      link2.scl <= 1'b0;
      tick(10);
    end
  endtask : frame2

  task automatic close2();
    link2.frame_enable <= 1'b1;
    link2.sda_host_o   <= ~link2.sda_host_o;
    tick(20);
    link2.scl <= 1'b1;
    tick(50);
  endtask : close2

  // Bench two-wire byte on the second link, 160 ns clock, ack sampled mid-high
  task automatic byte2(input logic [7:0] b);
    int k;
    for (k = 0; k < 9; k++) begin
      link2.sda_host_o <= (k < 8) ? b[7 - k] : 1'b1;
      tick(10);
      link2.scl <= 1'b1;
      tick(10);
      ack2 = ~link2.sda;
      tick(10);
      link2.scl <= 1'b0;
      tick(10);
    end
  endtask : byte2

  task automatic start2();
    link2.sda_host_o <= 1'b0;
    tick(10);
    link2.scl <= 1'b0;
    tick(10);
  endtask : start2

  task automatic stop2();
    link2.sda_host_o <= 1'b0;
    tick(10);
    link2.scl <= 1'b1;
    tick(10);
    link2.sda_host_o <= 1'b1;
    tick(20);
  endtask : stop2

  initial begin
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 8'h00;
    wb_dat = 32'h0;
    link2.scl = 1'b1;
    link2.frame_enable = 1'b1;
    link2.interface_select = 1'b1;
    link2.sda_host_o = 1'b1;
    link2.sda_host_oe = 1'b1;
    tick(12);
    rst_i <= 1'b0;
    tick(4);
    check(st1, exp_st(3'h0, 1'b0, 4'h0, 5'h00, 5'h00, 5'h00));
    check(st2, exp_st(3'h0, 1'b0, 4'h0, 5'h00, 5'h00, 5'h00));
    rdchk(CFG_OFS, 32'h0);
    wb(1'b1, 8'h10, 32'hFFFF_FFFF);
    rdchk(8'h10, 32'h0);
    rdchk(CMD_OFS, 32'h0);
    send(9'h00D);
    rdchk(STAT_OFS, 32'h4);
    check(st1, exp_st(3'h5, 1'b1, 4'h0, 5'h00, 5'h00, 5'h00));
    send(9'h0A5);
    check(st1, exp_st(3'h5, 1'b1, 4'h0, 5'h00, 5'h00, 5'h00));
    send(9'h14B);
    rdchk(STAT_OFS, 32'h0);
    check(st1, exp_st(3'h5, 1'b1, 4'hB, 5'h00, 5'h00, 5'h00));
    check(link1.sda, 1'b1);
    wb(1'b1, CFG_OFS, 32'h2);
    rdchk(CFG_OFS, 32'h2);
    send(9'h09F);
    send(9'h0C5);
    send(9'h1F2);
    rdchk(STAT_OFS, 32'h0);
    check(st1, exp_st(3'h5, 1'b1, 4'hB, 5'h1F, 5'h05, 5'h12));
    wb(1'b1, CFG_OFS, 32'h1);
    tick(10);
    send(9'h007);
    check(st1, exp_st(3'h7, 1'b0, 4'hB, 5'h1F, 5'h05, 5'h12));
    send(9'h043);
    send(9'h000);
    check(st1, exp_st(3'h0, 1'b0, 4'h3, 5'h1F, 5'h05, 5'h12));
    frame2(8'hEA, 10);
    check(st2, exp_st(3'h0, 1'b0, 4'h0, 5'h00, 5'h00, 5'h00));
    close2();
    check(st2, exp_st(3'h0, 1'b0, 4'h0, 5'h00, 5'h00, 5'h0A));
    frame2(8'h9F, 5);
    close2();
    check(st2, exp_st(3'h0, 1'b0, 4'h0, 5'h00, 5'h00, 5'h0A));
    frame2(8'h83, 8);
    close2();
    check(st2, exp_st(3'h0, 1'b0, 4'h0, 5'h03, 5'h00, 5'h0A));
    link2.interface_select <= 1'b0;
    link2.frame_enable     <= 1'b0;
    link2.sda_host_o       <= 1'b1;
    tick(10);
    start2();
    byte2(8'hFA);
    check(ack2, 1'b0);
    stop2();
    start2();
    byte2(8'hF8);
    check(ack2, 1'b1);
    byte2(8'h81);
    check(ack2, 1'b1);
    stop2();
    check(st2, exp_st(3'h0, 1'b0, 4'h0, 5'h01, 5'h00, 5'h0A));
    rst_i <= 1'b1;
    tick(4);
    rst_i <= 1'b0;
    tick(4);
    check(st1, exp_st(3'h0, 1'b0, 4'h0, 5'h00, 5'h00, 5'h00));
    check(st2, exp_st(3'h0, 1'b0, 4'h0, 5'h00, 5'h00, 5'h00));
    rdchk(CFG_OFS, 32'h0);
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
